/* File: bench/ctw_bus_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ctw_bus_model (
    // local driver, remote nodes and temperature setting
    input wire logic bus_drive_dominant,
    input wire logic remote_dom,
    input wire logic [7:0] temp_set,
    // seen by the transceiver
    output logic bus_dominant,
    output logic [7:0] junction_temp
);
    // wired bus: any dominant node wins
    assign bus_dominant = bus_drive_dominant | remote_dom;
    assign junction_temp = temp_set;
endmodule
`default_nettype wire

/* File: bench/tb_ctw_transceiver.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_ctw_transceiver;
    import ctw_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic bus_dominant, bus_drive_dominant, bus_bias_on, receive_output, remote_dom;
    logic [7:0] junction_temp, temp_set;
    int miscompares = 0;
    int checks_done = 0;
    int cyc = 0;
    ctw_transceiver i_ctw_transceiver (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_dominant(bus_dominant), .junction_temp(junction_temp),
        .bus_drive_dominant(bus_drive_dominant), .bus_bias_on(bus_bias_on),
        .receive_output(receive_output), .irq(irq));
    ctw_bus_model i_ctw_bus_model (.bus_drive_dominant(bus_drive_dominant), .remote_dom(remote_dom),
        .temp_set(temp_set), .bus_dominant(bus_dominant), .junction_temp(junction_temp));
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // whole run is well under a thousand cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            final_report();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ctl(input logic [4:0] v);
        apb(1'b1, CTW_OFF_CTRL, {27'h0, v});
    endtask
    task automatic pulse(input int n);
        remote_dom <= 1'b1;
        repeat (n) @(posedge pclk);
        remote_dom <= 1'b0;
    endtask
    // brief transmit-low probe, kept shorter than the stuck-low count
    task automatic probe(input string what, input logic exp);
        ctl(5'h02);
        repeat (3) @(posedge pclk);
        chk(what, bus_drive_dominant, exp);
        ctl(5'h03);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        remote_dom = 1'b0;
        temp_set = 8'h19;
        repeat (10) @(posedge pclk);
        chk("rx_reset", receive_output, 1'b1);
        presetn <= 1'b1;
        apb(1'b0, CTW_OFF_CTRL, 32'h0);
        chk("ctrl_reset", rd, {27'h0, CTW_CTRL_RST});
        chk("drive_reset", bus_drive_dominant, 1'b0);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped_err", err, 1'b1);
        chk("unmapped_data", rd, 32'h0);
        apb(1'b1, CTW_OFF_TIMING, 32'h0028_0002);
        apb(1'b1, 12'h018, 32'h0000_0008);
        apb(1'b1, CTW_OFF_IRQ_MASK, 32'h0000_0007);
        apb(1'b0, CTW_OFF_TIMING, 32'h0);
        chk("timing", rd, 32'h0028_0002);
        ctl(5'h02);
        repeat (3) @(posedge pclk);
        chk("tx_dom", bus_drive_dominant, 1'b1);
        chk("rx_dom", receive_output, 1'b0);
        chk("bias", bus_bias_on, 1'b1);
        repeat (12) @(posedge pclk);
        chk("stuck_off", bus_dominant, 1'b0);
        chk("stuck_irq", irq, 1'b1);
        apb(1'b1, CTW_OFF_IRQ_MASK, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq_masked", irq, 1'b0);
        apb(1'b1, CTW_OFF_IRQ_ST, 32'h0000_0007);
        apb(1'b1, CTW_OFF_IRQ_MASK, 32'h0000_0007);
        repeat (2) @(posedge pclk);
        chk("irq_clear", irq, 1'b0);
        ctl(5'h03);
        probe("stuck_rearm", 1'b1);
        temp_set <= 8'hab;
        repeat (4) @(posedge pclk);
        probe("tsd_off", 1'b0);
        pulse(4);
        chk("tsd_rx", receive_output, 1'b0);
        temp_set <= 8'h9c;
        repeat (4) @(posedge pclk);
        probe("tsd_hyst", 1'b0);
        temp_set <= 8'h9b;
        repeat (4) @(posedge pclk);
        probe("tsd_clear", 1'b1);
        ctl(5'h0b);
        apb(1'b0, CTW_OFF_STAT, 32'h0);
        chk("mode_sb", rd[5:4], 2'b01);
        repeat (4) begin
            pulse(1);
            repeat (3) @(posedge pclk);
        end
        chk("glitch_rx", receive_output, 1'b1);
        pulse(6);
        repeat (50) @(posedge pclk);
        chk("late_rx", receive_output, 1'b1);
        pulse(6);
        repeat (6) @(posedge pclk);
        pulse(6);
        repeat (4) @(posedge pclk);
        chk("wake_rx", receive_output, 1'b0);
        apb(1'b0, CTW_OFF_IRQ_ST, 32'h0);
        chk("wake_ev", rd[0], 1'b1);
        ctl(5'h03);
        ctl(5'h0b);
        repeat (4) @(posedge pclk);
        chk("reentry_rx", receive_output, 1'b1);
        ctl(5'h1b);
        apb(1'b0, CTW_OFF_STAT, 32'h0);
        chk("mode_off", rd[5:4], 2'b10);
        pulse(6);
        repeat (6) @(posedge pclk);
        pulse(6);
        repeat (4) @(posedge pclk);
        chk("off_rx", receive_output, 1'b1);
        final_report();
    end
endmodule
`default_nettype wire

/* File: inc/ctw_pkg.sv */
package ctw_pkg;
    // register byte offsets
    localparam logic [11:0] CTW_OFF_CTRL = 12'h000;
    localparam logic [11:0] CTW_OFF_STAT = 12'h004;
    localparam logic [11:0] CTW_OFF_IRQ_ST = 12'h008;
    localparam logic [11:0] CTW_OFF_IRQ_MASK = 12'h00c;
    localparam logic [11:0] CTW_OFF_TIMING = 12'h010;
    // control fields
    localparam int CTW_CTRL_TXD = 0;
    localparam int CTW_CTRL_ON = 1;
    localparam int CTW_CTRL_MUTE = 2;
    localparam int CTW_CTRL_LPS = 3;
    localparam int CTW_CTRL_OFF = 4;
    // reset values: undriven inputs pulled to their default levels
    localparam logic [4:0] CTW_CTRL_RST = 5'h03;
    // status / interrupt bits
    localparam int CTW_EV_WAKE = 0;
    localparam int CTW_EV_TSD = 1;
    localparam int CTW_EV_STUCK = 2;
    localparam logic [2:0] CTW_MASK_RST = 3'h0;
    // thermal thresholds in degrees C
    localparam logic [7:0] CTW_TSD_LIMIT = 8'haa;
    localparam logic [7:0] CTW_TSD_HYST_RST = 8'h0f;
    // timing in cycles of pclk
    localparam logic [15:0] CTW_GLITCH_RST = 16'h0004;
    localparam logic [15:0] CTW_WINDOW_RST = 16'h0040;
    localparam logic [15:0] CTW_STUCK_RST = 16'h0100;
    typedef enum logic [1:0] {
        CTW_NORMAL = 2'b00,
        CTW_STANDBY = 2'b01,
        CTW_SHUTDOWN = 2'b10
    } ctw_mode_e;
    typedef enum logic [1:0] {
        CTW_WK_IDLE = 2'b00,
        CTW_WK_DOM1 = 2'b01,
        CTW_WK_REC = 2'b10,
        CTW_WK_DONE = 2'b11
    } ctw_wake_e;
endpackage

/* File: rtl/ctw_transceiver.sv */
`timescale 1ns/10ps
`default_nettype none
// How it works
// - overheat disables the bus driver
// - overheat: bus recessive, receiver still works
// - resume only at or below limit minus hysteresis
// - transmit input resets high, recessive
// - turn-on input resets high, enabled
// - mute and low-power select reset low
// - bus level counts for wake after glitch time
// - wake needs filtered dominant within window
// - valid wake drives receive output low
// - receive output high in standby until wake
// - power-off disables driver, bias, receiver and wake, select picks mode
// - stuck-low transmit disables driver until rise
// - normal mode mirrors transmit onto bus
module ctw_transceiver
    import ctw_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // bus side
    input wire logic bus_dominant,
    input wire logic [7:0] junction_temp,
    output logic bus_drive_dominant,
    output logic bus_bias_on,
    output logic receive_output,
    // interrupt
    output logic irq
);
    logic [4:0] ctrl_q;
    logic [2:0] mask_q, ist_q;
    logic [7:0] hyst_q;
    logic [15:0] glitch_q, window_q, stuck_q;
    logic tsd_q, stuck_flag_q, txd_prev_q;
    logic [15:0] stuck_cnt_q, filt_cnt_q, win_cnt_q;
    logic filt_lvl_q, filt_prev_q;
    ctw_mode_e mode_q;
    ctw_wake_e wk_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q, irq_q, drv_q, bias_q, rxo_q;

    function automatic logic [15:0] inc16(input logic [15:0] v);
        inc16 = (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    wire acc = psel && penable && !pready_q;
    // writes land on the edge at which the master samples pready
    wire wr = psel && penable && pready_q && pwrite;
    wire hit_ctrl = paddr == CTW_OFF_CTRL;
    wire hit_stat = paddr == CTW_OFF_STAT;
    wire hit_ist = paddr == CTW_OFF_IRQ_ST;
    wire hit_mask = paddr == CTW_OFF_IRQ_MASK;
    wire hit_tim = paddr == CTW_OFF_TIMING;
    wire [11:0] hit_hyst = CTW_OFF_TIMING + 12'h004;
    wire hit_hy = paddr == hit_hyst;
    wire hit_stuck = paddr == (CTW_OFF_TIMING + 12'h008);
    wire mapped = hit_ctrl | hit_stat | hit_ist | hit_mask | hit_tim | hit_hy | hit_stuck;

    wire txd = ctrl_q[CTW_CTRL_TXD];
    wire turn_on = ctrl_q[CTW_CTRL_ON];
    wire mute = ctrl_q[CTW_CTRL_MUTE];
    wire lps = ctrl_q[CTW_CTRL_LPS];
    wire poff = ctrl_q[CTW_CTRL_OFF];
    // turn_on low also forces shutdown, like power-off
    ctw_mode_e mode_d;
    assign mode_d = (poff || !turn_on) ? CTW_SHUTDOWN : (lps ? CTW_STANDBY : CTW_NORMAL);

    wire [8:0] resume_lvl = {1'b0, CTW_TSD_LIMIT} - {1'b0, hyst_q};
    wire tsd_set = junction_temp > CTW_TSD_LIMIT;
    wire tsd_clr = ({1'b0, junction_temp} <= resume_lvl) && !resume_lvl[8];
    wire tsd_d = tsd_q ? !tsd_clr : tsd_set;

    wire stuck_hit = !txd && (stuck_cnt_q >= stuck_q);
    wire txd_rise = txd && !txd_prev_q;
    wire stuck_d = stuck_flag_q ? !txd_rise : stuck_hit;

    // filter: level accepted once stable longer than glitch time
    wire filt_change = bus_dominant != filt_lvl_q;
    // count must time the new level, else a short glitch is taken at once
    wire filt_accept = filt_change && (bus_dominant == filt_prev_q) && (filt_cnt_q >= glitch_q);
    wire dom_ok = filt_accept && bus_dominant;
    wire rec_ok = filt_accept && !bus_dominant;
    wire in_sb = mode_q == CTW_STANDBY;
    wire win_exp = win_cnt_q >= window_q;

    ctw_wake_e wk_d;
    always_comb begin
        wk_d = wk_q;
        if (!in_sb) begin
            wk_d = CTW_WK_IDLE;
        end else begin
            case (wk_q)
                CTW_WK_IDLE: if (dom_ok) wk_d = CTW_WK_DOM1;
                CTW_WK_DOM1: if (win_exp) wk_d = CTW_WK_IDLE; else if (rec_ok) wk_d = CTW_WK_REC;
                CTW_WK_REC: if (win_exp) wk_d = CTW_WK_IDLE; else if (dom_ok) wk_d = CTW_WK_DONE;
                CTW_WK_DONE: wk_d = CTW_WK_DONE;
                default: wk_d = CTW_WK_IDLE;
            endcase
        end
    end
    wire wake_ev = in_sb && (wk_q == CTW_WK_REC) && (wk_d == CTW_WK_DONE);

    wire drv_en = (mode_q == CTW_NORMAL) && !mute && !tsd_q && !stuck_flag_q;
    wire drv_d = drv_en && !txd;
    // normal mode rx mirrors bus, standby shows wake only
    wire rxo_d = (mode_q == CTW_NORMAL) ? !bus_dominant : !(in_sb && wk_q == CTW_WK_DONE);
    wire [2:0] ev = {stuck_hit && !stuck_flag_q, tsd_set && !tsd_q, wake_ev};
    wire [2:0] ist_wc = (wr && hit_ist) ? pwdata[2:0] : 3'h0;
    wire [2:0] ist_d = (ist_q & ~ist_wc) | ev;

    wire [31:0] rd_mux = hit_ctrl ? {27'h0, ctrl_q} :
                         hit_stat ? {24'h0, wk_q, mode_q, rxo_q, stuck_flag_q, tsd_q, drv_q} :
                         hit_ist ? {29'h0, ist_q} :
                         hit_mask ? {29'h0, mask_q} :
                         hit_tim ? {window_q, glitch_q} :
                         hit_hy ? {24'h0, hyst_q} :
                         hit_stuck ? {16'h0, stuck_q} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTW_CTRL_RST;
            mask_q <= CTW_MASK_RST;
            hyst_q <= CTW_TSD_HYST_RST;
            glitch_q <= CTW_GLITCH_RST;
            window_q <= CTW_WINDOW_RST;
            stuck_q <= CTW_STUCK_RST;
        end else if (wr) begin
            if (hit_ctrl) ctrl_q <= pwdata[4:0];
            if (hit_mask) mask_q <= pwdata[2:0];
            if (hit_hy) hyst_q <= pwdata[7:0];
            if (hit_tim) glitch_q <= pwdata[15:0];
            if (hit_tim) window_q <= pwdata[31:16];
            if (hit_stuck) stuck_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            ist_q <= 3'h0;
            irq_q <= 1'b0;
        end else begin
            pready_q <= acc;
            pslverr_q <= acc && !mapped;
            prdata_q <= (acc && !pwrite) ? rd_mux : 32'h0;
            ist_q <= ist_d;
            irq_q <= |(ist_d & mask_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= CTW_SHUTDOWN;
            tsd_q <= 1'b0;
            stuck_flag_q <= 1'b0;
            txd_prev_q <= 1'b1;
            stuck_cnt_q <= 16'h0;
            filt_lvl_q <= 1'b0;
            filt_prev_q <= 1'b0;
            filt_cnt_q <= 16'h0;
            win_cnt_q <= 16'h0;
            wk_q <= CTW_WK_IDLE;
            drv_q <= 1'b0;
            bias_q <= 1'b0;
            rxo_q <= 1'b1;
        end else begin
            mode_q <= mode_d;
            tsd_q <= tsd_d;
            stuck_flag_q <= stuck_d;
            txd_prev_q <= txd;
            stuck_cnt_q <= txd ? 16'h0 : inc16(stuck_cnt_q);
            filt_prev_q <= bus_dominant;
            filt_lvl_q <= filt_accept ? bus_dominant : filt_lvl_q;
            filt_cnt_q <= (bus_dominant != filt_prev_q) ? 16'h0 : inc16(filt_cnt_q);
            win_cnt_q <= (wk_d == CTW_WK_DOM1 && wk_q == CTW_WK_IDLE) ? 16'h0 : inc16(win_cnt_q);
            wk_q <= wk_d;
            drv_q <= drv_d;
            // recessive bias only in normal mode, else weak ground
            bias_q <= mode_d == CTW_NORMAL;
            rxo_q <= rxo_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign bus_drive_dominant = drv_q;
    assign bus_bias_on = bias_q;
    assign receive_output = rxo_q;
    assign irq = irq_q;

    property p_tsd_blocks;
        @(posedge pclk) disable iff (!presetn) tsd_q |=> !drv_q;
    endproperty
    a_tsd_blocks: assert property (p_tsd_blocks) else $error("driver active in thermal shutdown");
    property p_stuck_rel;
        @(posedge pclk) disable iff (!presetn) stuck_flag_q && !txd_rise |=> !drv_q;
    endproperty
    a_stuck_rel: assert property (p_stuck_rel) else $error("driver active after stuck low");
    property p_sb_rx_high;
        @(posedge pclk) disable iff (!presetn) in_sb && wk_q != CTW_WK_DONE |=> receive_output;
    endproperty
    a_sb_rx_high: assert property (p_sb_rx_high) else $error("rx low in standby before wake");
    property p_wake_rx;
        @(posedge pclk) disable iff (!presetn) wake_ev ##1 in_sb |=> !receive_output;
    endproperty
    a_wake_rx: assert property (p_wake_rx) else $error("rx not low after wake");
    property p_leave_sb;
        @(posedge pclk) disable iff (!presetn) !in_sb |=> wk_q == CTW_WK_IDLE;
    endproperty
    a_leave_sb: assert property (p_leave_sb) else $error("wake state kept outside standby");
    property p_off_mode;
        @(posedge pclk) disable iff (!presetn) poff |=> mode_q == CTW_SHUTDOWN ##1 !drv_q;
    endproperty
    a_off_mode: assert property (p_off_mode) else $error("power off not honoured");
    property p_normal_tx;
        @(posedge pclk) disable iff (!presetn) drv_en && !txd |=> bus_drive_dominant;
    endproperty
    a_normal_tx: assert property (p_normal_tx) else $error("transmit low not dominant");
    property p_window;
        @(posedge pclk) disable iff (!presetn) in_sb && wk_q == CTW_WK_REC && win_exp |=> wk_q != CTW_WK_DONE;
    endproperty
    a_window: assert property (p_window) else $error("wake after window");

    // apb handshake: one wait state, one-cycle answer
    property p_apb_ready;
        @(posedge pclk) disable iff (!presetn) psel && penable && !pready_q |=> pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("no ready after access");
    property p_apb_pulse;
        @(posedge pclk) disable iff (!presetn) pready |=> !pready;
    endproperty
    a_apb_pulse: assert property (p_apb_pulse) else $error("ready held too long");
    property p_apb_err;
        @(posedge pclk) disable iff (!presetn) pslverr |-> pready;
    endproperty
    a_apb_err: assert property (p_apb_err) else $error("error without ready");

    // thermal path
    property p_tsd_enter;
        @(posedge pclk) disable iff (!presetn) !tsd_q && junction_temp > CTW_TSD_LIMIT |=> tsd_q;
    endproperty
    a_tsd_enter: assert property (p_tsd_enter) else $error("overheat not entered");
    property p_tsd_hold;
        @(posedge pclk) disable iff (!presetn) tsd_q && !tsd_clr |=> tsd_q;
    endproperty
    a_tsd_hold: assert property (p_tsd_hold) else $error("overheat left inside hysteresis");
    property p_tsd_rx;
        @(posedge pclk) disable iff (!presetn) tsd_q && mode_q == CTW_NORMAL && bus_dominant |=> !receive_output;
    endproperty
    a_tsd_rx: assert property (p_tsd_rx) else $error("receiver stopped in overheat");
    property p_tsd_bias;
        @(posedge pclk) disable iff (!presetn) tsd_q && mode_d == CTW_NORMAL |=> bus_bias_on;
    endproperty
    a_tsd_bias: assert property (p_tsd_bias) else $error("recessive bias lost in overheat");

    // filter and stuck-low timers
    property p_glitch_hold;
        @(posedge pclk) disable iff (!presetn) bus_dominant != filt_prev_q |=> filt_lvl_q == $past(filt_lvl_q);
    endproperty
    a_glitch_hold: assert property (p_glitch_hold) else $error("filter took an unsettled level");
    property p_stuck_set;
        @(posedge pclk) disable iff (!presetn) !txd && stuck_cnt_q >= stuck_q |=> stuck_flag_q;
    endproperty
    a_stuck_set: assert property (p_stuck_set) else $error("stuck low not flagged");
    property p_stuck_clear;
        @(posedge pclk) disable iff (!presetn) stuck_flag_q && txd_rise |=> !stuck_flag_q;
    endproperty
    a_stuck_clear: assert property (p_stuck_clear) else $error("stuck flag kept after rise");

    // wake recognition in steps
    sequence s_wake_rec;
        in_sb && wk_q == CTW_WK_REC && !win_exp;
    endsequence
    sequence s_wake_dom;
        dom_ok && mode_d == CTW_STANDBY;
    endsequence
    property p_wake_done;
        @(posedge pclk) disable iff (!presetn) s_wake_rec ##0 s_wake_dom |=> wk_q == CTW_WK_DONE ##1 !receive_output;
    endproperty
    a_wake_done: assert property (p_wake_done) else $error("wake not recognised");
    property p_ist_sticky;
        @(posedge pclk) disable iff (!presetn) ist_q[CTW_EV_WAKE] && !(wr && hit_ist) |=> ist_q[CTW_EV_WAKE];
    endproperty
    a_ist_sticky: assert property (p_ist_sticky) else $error("wake status lost");

    // mode outputs
    property p_normal_rx;
        @(posedge pclk) disable iff (!presetn) mode_q == CTW_NORMAL && !bus_dominant |=> receive_output;
    endproperty
    a_normal_rx: assert property (p_normal_rx) else $error("rx low on recessive bus");
    property p_off_rx;
        @(posedge pclk) disable iff (!presetn) mode_q == CTW_SHUTDOWN |=> receive_output;
    endproperty
    a_off_rx: assert property (p_off_rx) else $error("rx low in power off");
    property p_sb_quiet;
        @(posedge pclk) disable iff (!presetn) in_sb |=> !bus_drive_dominant;
    endproperty
    a_sb_quiet: assert property (p_sb_quiet) else $error("driver active in standby");
endmodule
`default_nettype wire
